//--- core/prc_top.v
// Reset and MII pin mode controller, top level
//
// Notes on behaviour
// - Reset pin low or soft reset bit resets
// - Reset cycle extended 258 us after release
// - Hardware reset: data low, clocks high
// - Power-down: clocks run, data outputs low
// - Transmit inputs weakly pulled down in modes
// - LED pins show status chosen by register
// - LED pins give initial configuration levels
// - Transmit clock 2.5 or 25 MHz by speed
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
`include "prc_consts.vh"

module prc_top #(
  parameter        CNT_W      = 17,
  parameter [31:0] RST_CYCLES = `PRC_RST_EXT_CYCLES,
  parameter        STAT_W     = 16
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              hw_reset_n,
  input  wire [4:0]        reg_addr,
  input  wire [15:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [15:0]       reg_rdata,
  input  wire [3:0]        core_rxd,
  input  wire              core_rx_dv,
  input  wire              core_rx_er,
  input  wire              core_col,
  input  wire              core_crs,
  input  wire [STAT_W-1:0] led_status,
  output reg  [3:0]        core_txd,
  output reg               core_tx_en,
  input  wire [3:0]        mii_txd,
  input  wire              mii_tx_en,
  output reg  [3:0]        mii_rxd,
  output reg               mii_rx_dv,
  output reg               mii_rx_er,
  output reg               mii_col,
  output reg               mii_crs,
  output reg               mii_tx_clk,
  output reg               mii_rx_clk,
  output reg               mii_out_oe,
  output reg               mii_out_weak_pulldown,
  output reg               mii_txd_weak_pulldown,
  input  wire              led_cfg_pin_1_in,
  input  wire              led_cfg_pin_2_in,
  input  wire              led_cfg_pin_3_in,
  output wire              led_cfg_pin_1_out,
  output wire              led_cfg_pin_2_out,
  output wire              led_cfg_pin_3_out,
  output wire              led_cfg_pin_1_oe,
  output wire              led_cfg_pin_2_oe,
  output wire              led_cfg_pin_3_oe,
  output reg               hardware_reset_state,
  output reg               soft_power_down_state,
  output reg               mii_state_a
);

  // ****************************************
  // Mode encoding
  // ****************************************
  localparam [3:0] MODE_RST = 4'h1;
  localparam [3:0] MODE_ISO = 4'h2;
  localparam [3:0] MODE_PDN = 4'h4;
  localparam [3:0] MODE_RUN = 4'h8;

  // ****************************************
  // Declarations
  // ****************************************
  reg  [15:0] ctrl_r;
  reg  [15:0] ledcfg_r;
  reg  [2:0]  cfg_r;
  reg  [2:0]  led_out_r;
  reg  [2:0]  led_oe_r;
  reg  [3:0]  mode_nxt;
  reg  [15:0] rdata_nxt;
  wire        in_reset;
  wire        rst_done;
  wire        div_clk;
  wire        wr_ctrl;
  wire        wr_led;
  wire        sw_start;
  wire [2:0]  led_pin_in;
  wire [`PRC_LED_SEL_W-1:0] led_sel [0:2];

  // ****************************************
  // Status source selection
  // ****************************************
  function sel_status;
    input [STAT_W-1:0]         vec;
    input [`PRC_LED_SEL_W-1:0] sel;
    begin
      sel_status = vec[sel];
    end
  endfunction

  // ****************************************
  // Register decode
  // ****************************************
  assign wr_ctrl  = reg_wr & (reg_addr == `PRC_ADDR_CTRL);
  assign wr_led   = reg_wr & (reg_addr == `PRC_ADDR_LEDCFG);
  assign sw_start = wr_ctrl & reg_wdata[`PRC_CTRL_SRST];

  // ****************************************
  // Reset extension and clock divider
  // ****************************************
  prc_rst_ext #(
    .CNT_W      (CNT_W),
    .RST_CYCLES (RST_CYCLES)
  ) u_rst (
    .clk        (clk),
    .reset      (reset),
    .hw_reset_n (hw_reset_n),
    .sw_start   (sw_start),
    .in_reset_r (in_reset),
    .done_r     (rst_done)
  );

  prc_clk_div u_div (
    .clk       (clk),
    .reset     (reset),
    .run       (~in_reset),
    .speed_100 (ctrl_r[`PRC_CTRL_SPEED]),
    .clk_out_r (div_clk)
  );

  // ****************************************
  // Control and LED configuration registers
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r   <= `PRC_CTRL_RST_VAL;
      ledcfg_r <= `PRC_LEDCFG_RST_VAL;
      cfg_r    <= 3'h0;
    end else begin
      if (rst_done) begin
        ctrl_r[`PRC_CTRL_SRST]   <= 1'b0;
        cfg_r                    <= led_pin_in;
        ctrl_r[`PRC_CTRL_SPEED]  <= led_pin_in[0];
        ctrl_r[`PRC_CTRL_DUPLEX] <= led_pin_in[1];
        ctrl_r[`PRC_CTRL_ANEG]   <= led_pin_in[2];
      end
      if (in_reset) begin
        ctrl_r[`PRC_CTRL_PDN] <= 1'b0;
        ctrl_r[`PRC_CTRL_ISO] <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata | {ctrl_r[`PRC_CTRL_SRST] & ~rst_done, 15'h0000};
      end
      if (wr_led) begin
        ledcfg_r <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `PRC_ADDR_CTRL: begin
          rdata_nxt = ctrl_r;
        end
        `PRC_ADDR_LEDCFG: begin
          rdata_nxt = ledcfg_r;
        end
        `PRC_ADDR_STAT: begin
          rdata_nxt[`PRC_STAT_CFG_LSB+2:`PRC_STAT_CFG_LSB] = cfg_r;
          rdata_nxt[`PRC_STAT_INRST] = in_reset;
          rdata_nxt[`PRC_STAT_PDN]   = soft_power_down_state;
          rdata_nxt[`PRC_STAT_ISO]   = mii_state_a;
          rdata_nxt[`PRC_STAT_SPEED] = ctrl_r[`PRC_CTRL_SPEED];
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // Pin mode selection
  // ****************************************
  always @* begin
    if (in_reset) begin
      mode_nxt = MODE_RST;
    end else if (ctrl_r[`PRC_CTRL_ISO]) begin
      mode_nxt = MODE_ISO;
    end else if (ctrl_r[`PRC_CTRL_PDN]) begin
      mode_nxt = MODE_PDN;
    end else begin
      mode_nxt = MODE_RUN;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mii_rxd               <= 4'h0;
      mii_rx_dv             <= 1'b0;
      mii_rx_er             <= 1'b0;
      mii_col               <= 1'b0;
      mii_crs               <= 1'b0;
      mii_tx_clk            <= 1'b1;
      mii_rx_clk            <= 1'b1;
      mii_out_oe            <= 1'b1;
      mii_out_weak_pulldown <= 1'b0;
      mii_txd_weak_pulldown <= 1'b1;
      core_txd              <= 4'h0;
      core_tx_en            <= 1'b0;
      hardware_reset_state  <= 1'b1;
      soft_power_down_state <= 1'b0;
      mii_state_a           <= 1'b0;
    end else begin
      hardware_reset_state  <= (mode_nxt == MODE_RST);
      soft_power_down_state <= (mode_nxt == MODE_PDN);
      mii_state_a           <= (mode_nxt == MODE_ISO);
      mii_txd_weak_pulldown <= (mode_nxt != MODE_RUN);
      case (mode_nxt)
        MODE_RST: begin
          mii_rxd               <= 4'h0;
          mii_rx_dv             <= 1'b0;
          mii_rx_er             <= 1'b0;
          mii_col               <= 1'b0;
          mii_crs               <= 1'b0;
          mii_tx_clk            <= 1'b1;
          mii_rx_clk            <= 1'b1;
          mii_out_oe            <= 1'b1;
          mii_out_weak_pulldown <= 1'b0;
          core_txd              <= 4'h0;
          core_tx_en            <= 1'b0;
        end
        MODE_ISO: begin
          mii_rxd               <= 4'h0;
          mii_rx_dv             <= 1'b0;
          mii_rx_er             <= 1'b0;
          mii_col               <= 1'b0;
          mii_crs               <= 1'b0;
          mii_tx_clk            <= 1'b0;
          mii_rx_clk            <= 1'b0;
          mii_out_oe            <= 1'b0;
          mii_out_weak_pulldown <= 1'b1;
          core_txd              <= 4'h0;
          core_tx_en            <= 1'b0;
        end
        MODE_PDN: begin
          mii_rxd               <= 4'h0;
          mii_rx_dv             <= 1'b0;
          mii_rx_er             <= 1'b0;
          mii_col               <= 1'b0;
          mii_crs               <= 1'b0;
          mii_tx_clk            <= div_clk;
          mii_rx_clk            <= div_clk;
          mii_out_oe            <= 1'b1;
          mii_out_weak_pulldown <= 1'b0;
          core_txd              <= 4'h0;
          core_tx_en            <= 1'b0;
        end
        MODE_RUN: begin
          mii_rxd               <= core_rxd;
          mii_rx_dv             <= core_rx_dv;
          mii_rx_er             <= core_rx_er;
          mii_col               <= core_col;
          mii_crs               <= core_crs;
          mii_tx_clk            <= div_clk;
          mii_rx_clk            <= div_clk;
          mii_out_oe            <= 1'b1;
          mii_out_weak_pulldown <= 1'b0;
          core_txd              <= mii_txd;
          core_tx_en            <= mii_tx_en;
        end
        default: begin
          mii_rxd               <= 4'h0;
          mii_rx_dv             <= 1'b0;
          mii_rx_er             <= 1'b0;
          mii_col               <= 1'b0;
          mii_crs               <= 1'b0;
          mii_tx_clk            <= 1'b1;
          mii_rx_clk            <= 1'b1;
          mii_out_oe            <= 1'b1;
          mii_out_weak_pulldown <= 1'b0;
          core_txd              <= 4'h0;
          core_tx_en            <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Shared LED and configuration pins
  // ****************************************
  assign led_pin_in = {led_cfg_pin_3_in, led_cfg_pin_2_in, led_cfg_pin_1_in};
  assign led_sel[0] = ledcfg_r[`PRC_LED1_LSB+`PRC_LED_SEL_W-1:`PRC_LED1_LSB];
  assign led_sel[1] = ledcfg_r[`PRC_LED2_LSB+`PRC_LED_SEL_W-1:`PRC_LED2_LSB];
  assign led_sel[2] = ledcfg_r[`PRC_LED3_LSB+`PRC_LED_SEL_W-1:`PRC_LED3_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_led
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          led_out_r[gi] <= 1'b0;
          led_oe_r[gi]  <= 1'b0;
        end else if (in_reset) begin
          led_out_r[gi] <= 1'b0;
          led_oe_r[gi]  <= 1'b0;
        end else begin
          led_out_r[gi] <= sel_status(led_status, led_sel[gi]);
          led_oe_r[gi]  <= 1'b1;
        end
      end
    end
  endgenerate

  assign led_cfg_pin_1_out = led_out_r[0];
  assign led_cfg_pin_2_out = led_out_r[1];
  assign led_cfg_pin_3_out = led_out_r[2];
  assign led_cfg_pin_1_oe  = led_oe_r[0];
  assign led_cfg_pin_2_oe  = led_oe_r[1];
  assign led_cfg_pin_3_oe  = led_oe_r[2];

endmodule

//--- core/prc_consts.vh
// Constants for the reset and pin mode controller
`ifndef PRC_CONSTS_VH
`define PRC_CONSTS_VH

// ****************************************
// Register addresses
// ****************************************
`define PRC_ADDR_CTRL      5'h00
`define PRC_ADDR_STAT      5'h11
`define PRC_ADDR_LEDCFG    5'h14

// ****************************************
// Control register fields
// ****************************************
`define PRC_CTRL_SRST      15
`define PRC_CTRL_SPEED     13
`define PRC_CTRL_ANEG      12
`define PRC_CTRL_PDN       11
`define PRC_CTRL_ISO       10
`define PRC_CTRL_DUPLEX    8
`define PRC_CTRL_RST_VAL   16'h0000

// ****************************************
// Status register fields
// ****************************************
`define PRC_STAT_CFG_LSB   0
`define PRC_STAT_INRST     4
`define PRC_STAT_PDN       5
`define PRC_STAT_ISO       6
`define PRC_STAT_SPEED     7

// ****************************************
// LED configuration fields
// ****************************************
`define PRC_LED1_LSB       12
`define PRC_LED2_LSB       8
`define PRC_LED3_LSB       4
`define PRC_LED_SEL_W      4
`define PRC_LEDCFG_RST_VAL 16'h0120

// ****************************************
// Timing
// ****************************************
`define PRC_CLK_KHZ        200000
`define PRC_RST_EXT_US     258
`define PRC_RST_EXT_CYCLES ((`PRC_RST_EXT_US * `PRC_CLK_KHZ + 999) / 1000)
`define PRC_MII_100_KHZ    25000
`define PRC_MII_10_KHZ     2500
`define PRC_HALF_100       (`PRC_CLK_KHZ / (2 * `PRC_MII_100_KHZ))
`define PRC_HALF_10        (`PRC_CLK_KHZ / (2 * `PRC_MII_10_KHZ))

`endif

//--- core/prc_rst_ext.v
// Reset combiner and reset cycle extender
`timescale 1ns/100ps
`include "prc_consts.vh"

module prc_rst_ext #(
  parameter        CNT_W      = 17,
  parameter [31:0] RST_CYCLES = `PRC_RST_EXT_CYCLES
) (
  input  wire clk,
  input  wire reset,
  input  wire hw_reset_n,
  input  wire sw_start,
  output reg  in_reset_r,
  output reg  done_r
);

  localparam [CNT_W-1:0] LOAD = RST_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  reg  [CNT_W-1:0] cnt_r;
  wire             src;

  // ****************************************
  // Reset sources and stretch counter
  // ****************************************
  assign src = ~hw_reset_n | sw_start;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r      <= LOAD;
      in_reset_r <= 1'b1;
      done_r     <= 1'b0;
    end else if (src) begin
      cnt_r      <= LOAD;
      in_reset_r <= 1'b1;
      done_r     <= 1'b0;
    end else if (cnt_r != {CNT_W{1'b0}}) begin
      cnt_r <= cnt_r - ONE;
      if (cnt_r == ONE) begin
        in_reset_r <= 1'b0;
        done_r     <= 1'b1;
      end else begin
        done_r <= 1'b0;
      end
    end else begin
      done_r <= 1'b0;
    end
  end

endmodule

//--- core/prc_clk_div.v
// Transmit and receive clock divider
`timescale 1ns/100ps
`include "prc_consts.vh"

module prc_clk_div #(
  parameter        CW      = 6,
  parameter [31:0] HALF100 = `PRC_HALF_100,
  parameter [31:0] HALF10  = `PRC_HALF_10
) (
  input  wire clk,
  input  wire reset,
  input  wire run,
  input  wire speed_100,
  output reg  clk_out_r
);

  localparam [CW-1:0] END100 = HALF100[CW-1:0] - 1'b1;
  localparam [CW-1:0] END10  = HALF10[CW-1:0] - 1'b1;
  localparam [CW-1:0] ONE    = {{(CW-1){1'b0}}, 1'b1};

  reg  [CW-1:0] cnt_r;
  wire [CW-1:0] lim;

  // ****************************************
  // Divider
  // ****************************************
  assign lim = speed_100 ? END100 : END10;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r     <= {CW{1'b0}};
      clk_out_r <= 1'b1;
    end else if (!run) begin
      cnt_r     <= {CW{1'b0}};
      clk_out_r <= 1'b1;
    end else if (cnt_r >= lim) begin
      cnt_r     <= {CW{1'b0}};
      clk_out_r <= ~clk_out_r;
    end else begin
      cnt_r <= cnt_r + ONE;
    end
  end

endmodule

//--- verification/prc_top_monitor.sv
// Assertion checker for the reset and pin mode controller
`timescale 1ns/100ps
`include "prc_consts.vh"
module prc_top_monitor #(
  parameter [31:0] RST_CYCLES = `PRC_RST_EXT_CYCLES
) (
  input wire        clk,
  input wire        reset,
  input wire        hw_reset_n,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire [3:0]  core_rxd,
  input wire        core_rx_dv,
  input wire        core_rx_er,
  input wire        core_col,
  input wire        core_crs,
  input wire [3:0]  core_txd,
  input wire        core_tx_en,
  input wire [3:0]  mii_txd,
  input wire        mii_tx_en,
  input wire [3:0]  mii_rxd,
  input wire        mii_rx_dv,
  input wire        mii_rx_er,
  input wire        mii_col,
  input wire        mii_crs,
  input wire        mii_tx_clk,
  input wire        mii_rx_clk,
  input wire        mii_out_oe,
  input wire        mii_out_weak_pulldown,
  input wire        mii_txd_weak_pulldown,
  input wire        led_cfg_pin_1_oe,
  input wire        led_cfg_pin_2_oe,
  input wire        led_cfg_pin_3_oe,
  input wire        hardware_reset_state,
  input wire        soft_power_down_state,
  input wire        mii_state_a
);
  reg [31:0] since_r;
  wire       quiet;
  wire       led_oe;
  wire       run;
  wire       soft_wr;
  assign quiet   = !(|mii_rxd) && !mii_rx_dv && !mii_rx_er && !mii_col && !mii_crs;
  assign led_oe  = led_cfg_pin_1_oe && led_cfg_pin_2_oe && led_cfg_pin_3_oe;
  assign run     = !hardware_reset_state && !soft_power_down_state && !mii_state_a;
  assign soft_wr = reg_wr && reg_addr == `PRC_ADDR_CTRL && reg_wdata[`PRC_CTRL_SRST];
  // ****
  // Cycles since the last reset request
  // ****
  always @(posedge clk) begin
    if (reset || !hw_reset_n || soft_wr) begin
      since_r <= 32'h0;
    end else begin
      since_r <= since_r + 32'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_pin_reset: assert property (!hw_reset_n |-> ##[1:3] hardware_reset_state)
    else $error("reset pin ignored");
  chk_soft_reset: assert property (reg_wr && reg_addr == `PRC_ADDR_CTRL &&
    reg_wdata[`PRC_CTRL_SRST] |-> ##[1:3] hardware_reset_state)
    else $error("soft reset ignored");
  chk_reset_len: assert property ($fell(hardware_reset_state) |-> since_r >= RST_CYCLES)
    else $error("reset cycle too short");
  chk_reset_data: assert property (hardware_reset_state |-> quiet && mii_out_oe)
    else $error("data not low in reset");
  chk_reset_clks: assert property (hardware_reset_state &&
    $past(hardware_reset_state, 3) |-> mii_tx_clk && mii_rx_clk)
    else $error("clocks not high in reset");
  chk_pdn_data: assert property (soft_power_down_state |-> quiet && mii_out_oe)
    else $error("data not low in power-down");
  chk_iso_float: assert property (mii_state_a |-> !mii_out_oe && mii_out_weak_pulldown)
    else $error("outputs driven in mii_state_a");
  chk_tx_pull: assert property (mii_txd_weak_pulldown ==
    (hardware_reset_state || soft_power_down_state || mii_state_a))
    else $error("transmit pull-down wrong");
  chk_led_hold: assert property (hardware_reset_state &&
    $past(hardware_reset_state) |-> !led_cfg_pin_1_oe && !led_cfg_pin_2_oe && !led_cfg_pin_3_oe)
    else $error("led pins driven in reset");
  chk_led_drive: assert property ($fell(hardware_reset_state) |-> ##[0:1] led_oe)
    else $error("led pins not driven");
  chk_rx_pass: assert property (run |-> {mii_rxd, mii_rx_dv, mii_rx_er, mii_col, mii_crs} ==
    $past({core_rxd, core_rx_dv, core_rx_er, core_col, core_crs}))
    else $error("receive outputs not passed");
  chk_tx_pass: assert property (run |-> {core_txd, core_tx_en} == $past({mii_txd, mii_tx_en}))
    else $error("transmit inputs not passed");
  chk_tx_block: assert property (!run |-> core_txd == 4'h0 && !core_tx_en)
    else $error("transmit inputs not blocked");
  chk_clk_pair: assert property (mii_out_oe |-> mii_rx_clk == mii_tx_clk)
    else $error("receive clock differs");
  cov_pdn: cover property (soft_power_down_state);
  cov_iso: cover property (mii_state_a);
  cov_out: cover property ($fell(hardware_reset_state));
endmodule

//--- verification/prc_mac_model.sv
// Media access controller model on the transmit side
`timescale 1ns/100ps
module prc_mac_model (
  input  wire       tx_clk,
  output reg  [3:0] txd,
  output reg        tx_en
);
  reg [7:0] s_r;
  initial begin
    s_r = 8'h5a;
    txd = 4'h0;
    tx_en = 1'b0;
  end
  // ****
  // Data launched on the transmit clock
  // ****
  always @(posedge tx_clk) begin
    s_r <= {s_r[6:0], s_r[7] ^ s_r[5] ^ s_r[4] ^ s_r[3]};
    txd <= s_r[3:0];
    tx_en <= s_r[7];
  end
endmodule

//--- verification/tb.sv
// Self-checking bench for the reset and pin mode controller
`timescale 1ns/100ps
`include "prc_consts.vh"
module tb;
  localparam RC = 20;
  reg clk = 1'b0, reset = 1'b1, hw_reset_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg [4:0] reg_addr = 5'h00;
  reg [15:0] reg_wdata = 16'h0000, led_status = 16'h0000, ls_prev = 16'h0000;
  reg [3:0] core_rxd = 4'h0;
  reg core_rx_dv = 1'b0, core_rx_er = 1'b0, core_col = 1'b0, core_crs = 1'b0;
  reg [2:0] strap = 3'h5;
  reg [31:0] lf = 32'h00016d13;
  wire [15:0] reg_rdata;
  wire [3:0] core_txd, mii_txd, mii_rxd;
  wire core_tx_en, mii_tx_en, mii_rx_dv, mii_rx_er, mii_col, mii_crs, mii_tx_clk, mii_rx_clk;
  wire mii_out_oe, mii_out_weak_pulldown, mii_txd_weak_pulldown;
  wire led_cfg_pin_1_out, led_cfg_pin_2_out, led_cfg_pin_3_out;
  wire led_cfg_pin_1_oe, led_cfg_pin_2_oe, led_cfg_pin_3_oe;
  wire hardware_reset_state, soft_power_down_state, mii_state_a;
  wire led_cfg_pin_1_in = led_cfg_pin_1_oe ? led_cfg_pin_1_out : strap[0];
  wire led_cfg_pin_2_in = led_cfg_pin_2_oe ? led_cfg_pin_2_out : strap[1];
  wire led_cfg_pin_3_in = led_cfg_pin_3_oe ? led_cfg_pin_3_out : strap[2];
  wire tx_clk_w = mii_out_oe & mii_tx_clk;
  integer err_total = 0, total_checks = 0, cyc = 0, i;
  reg [15:0] exp_q[$];
  reg rd_d = 1'b0;
  prc_top #(.RST_CYCLES(RC)) i_prc_top (.*);
  prc_mac_model i_prc_mac_model (.tx_clk(tx_clk_w), .txd(mii_txd), .tx_en(mii_tx_en));
  always #2.5 clk = ~clk;
  // ****
  // Helpers
  // ****
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [15:0] st(input [2:0] s);
    st = {8'h00, s[0], 4'h0, s};
  endfunction
  function [15:0] ce(input [2:0] s);
    ce = {2'b00, s[0], s[2], 3'b000, s[1], 8'h00};
  endfunction
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input ok, input [8*16-1:0] m);
    total_checks = total_checks + 1;
    if (ok !== 1'b1) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: %0s", $time, m);
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [4:0] a, input [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task rst_len;
    integer n;
    n = 0;
    while (hardware_reset_state === 1'b1 && n < 99) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    chk(n >= RC && n <= RC + 3, "reset length");
  endtask
  task half(input integer e);
    integer n;
    reg c;
    c = mii_tx_clk;
    @(posedge clk);
    while (mii_tx_clk === c) @(posedge clk);
    c = mii_tx_clk;
    n = 0;
    while (mii_tx_clk === c && n < 99) begin
      @(posedge clk);
      n = n + 1;
    end
    chk(n == e, "clock half");
  endtask
  // ****
  // Stimulus, read checker and watchdog
  // ****
  always @(posedge clk) begin
    lf <= lfsr(lf);
    ls_prev <= led_status;
    {core_rxd, core_rx_dv, core_rx_er, core_col, core_crs} <= lf[7:0];
    led_status <= lf[31:16];
    rd_d <= reg_rd;
    if (rd_d)
      chk(reg_rdata === exp_q.pop_front(), "read data");
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rst_len;
    rd(`PRC_ADDR_STAT, st(strap));
    rd(`PRC_ADDR_CTRL, ce(strap));
    rd(`PRC_ADDR_LEDCFG, `PRC_LEDCFG_RST_VAL);
    rd(5'h03, 16'h0000);
    for (i = 0; i < 16; i = i + 1) begin
      wr(`PRC_ADDR_LEDCFG, {i[3:0], ~i[3:0], i[3:0] + 4'h5, 4'h0});
      repeat (2) @(posedge clk);
      #1;
      chk(led_cfg_pin_1_out === ls_prev[i] && led_cfg_pin_2_out === ls_prev[15 - i] &&
        led_cfg_pin_3_out === ls_prev[(i + 5) % 16], "led select");
    end
    chk(led_cfg_pin_1_oe & led_cfg_pin_2_oe & led_cfg_pin_3_oe, "led drive");
    for (i = 0; i < 2; i = i + 1) begin
      wr(`PRC_ADDR_CTRL, {2'b00, i[0], 2'b01, 11'h000});
      repeat (3) @(posedge clk);
      chk(soft_power_down_state === 1'b1 && mii_rxd === 4'h0, "power down");
      half(i ? `PRC_HALF_100 : `PRC_HALF_10);
    end
    wr(`PRC_ADDR_CTRL, 16'h0400);
    repeat (3) @(posedge clk);
    chk(mii_state_a && !mii_out_oe && mii_out_weak_pulldown, "mii_state_a");
    chk(mii_txd_weak_pulldown === 1'b1, "tx pull-down");
    wr(`PRC_ADDR_CTRL, 16'h8000);
    repeat (2) @(posedge clk);
    chk(hardware_reset_state === 1'b1, "soft reset");
    rd(`PRC_ADDR_CTRL, 16'h8000);
    strap <= lf[2:0];
    repeat (RC + 4) @(posedge clk);
    rd(`PRC_ADDR_CTRL, ce(strap));
    rd(`PRC_ADDR_STAT, st(strap));
    half(strap[0] ? `PRC_HALF_100 : `PRC_HALF_10);
    hw_reset_n <= 1'b0;
    strap <= ~strap;
    repeat (6) @(posedge clk);
    #1;
    chk(hardware_reset_state && mii_tx_clk && mii_rx_clk && mii_rxd === 4'h0, "pin reset");
    @(posedge clk);
    hw_reset_n <= 1'b1;
    rst_len;
    rd(`PRC_ADDR_STAT, st(strap));
    repeat (2) @(posedge clk);
    report_and_stop;
  end
endmodule
bind prc_top prc_top_monitor #(.RST_CYCLES(RST_CYCLES)) i_prc_top_monitor (.*);
